// ### src/rst_seq_pkg.sv
// Package for the revision aware reset sequencer: revision codes,
// monitor threshold codes and startup timing constants.
// Assumes a 200 MHz system clock.
package rst_seq_pkg;

	// Silicon revision selector
	typedef enum logic [1:0] {
		REV_FIRST  = 2'b00,
		REV_SECOND = 2'b01,
		REV_THIRD  = 2'b10
	} revision_t;

	// Edge monitor threshold selection; low is the power-on default
	localparam logic THRESH_LOW  = 1'b0;
	localparam logic THRESH_HIGH = 1'b1;

	// Clock period in picoseconds
	localparam longint CLK_PERIOD_PS = 64'd5000;

	// Long hold-off of the first revision, in milliseconds
	localparam longint FIRST_HOLD_MS     = 64'd80;
	localparam longint FIRST_HOLD_CYCLES = (FIRST_HOLD_MS * 64'd1000000000) / CLK_PERIOD_PS;

	// Short startup hold of later revisions and of later releases on the first, in microseconds
	localparam longint SHORT_HOLD_US     = 64'd350;
	localparam longint SHORT_HOLD_CYCLES = (SHORT_HOLD_US * 64'd1000000 + CLK_PERIOD_PS - 64'd1)
		/ CLK_PERIOD_PS;

	// Cycles spent calibrating the core regulator
	localparam longint CAL_CYCLES = 64'd16;

	// Width of the startup counter
	localparam int HOLD_W = 24;

endpackage : rst_seq_pkg

// ### src/sync2.sv
// Two flip-flop synchroniser for one level.
// Assumes the input comes from outside the CLK domain.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic CLK,
	input  wire logic RESETN,
	input  wire logic D,
	output logic      Q
);
	logic meta;

	// Only the second stage reads the first; reset to the idle level of the
	// input so that no false event appears right after reset
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			meta <= RESET_VAL;
			Q    <= RESET_VAL;
		end else begin
			meta <= D;
			Q    <= meta;
		end
	end
endmodule // sync2
`default_nettype wire

// ### src/revision_aware_reset_sequencer.sv
// Revision aware reset sequencer: combines power-on reset and two supply
// monitors, drives the external reset pin and times the core release.
// Assumes RESETN is the power-on reset; monitor and pin inputs are async.
`timescale 1ns/1ps
`default_nettype none
module revision_aware_reset_sequencer
	import rst_seq_pkg::*;
#(
	parameter revision_t REVISION   = REV_THIRD,
	parameter longint    LONG_HOLD  = FIRST_HOLD_CYCLES,
	parameter longint    SHORT_HOLD = SHORT_HOLD_CYCLES
) (
	input  wire logic CLK,
	input  wire logic RESETN,
	input  wire logic EDGE_MON_BELOW,
	input  wire logic LEVEL_MON_BELOW,
	input  wire logic RST_PIN_IN,
	input  wire logic HIGH_THRESH_REQ,
	input  wire logic REG_BELOW_HIGH,
	output logic      RST_PIN_OUT,
	output logic      RST_PIN_OE,
	output logic      CORE_RESETN,
	output logic      THRESH_SEL,
	output logic      CAL_START,
	output logic      LOCKED
);

	localparam logic [HOLD_W-1:0] LONG_CNT  = HOLD_W'(LONG_HOLD);
	localparam logic [HOLD_W-1:0] SHORT_CNT = HOLD_W'(SHORT_HOLD);
	localparam logic [HOLD_W-1:0] CAL_CNT   = HOLD_W'(CAL_CYCLES);

	localparam logic EARLY_REV = (REVISION != REV_THIRD);
	localparam logic HAS_LEVEL = (REVISION == REV_THIRD);
	localparam logic DRIVE_PIN = (REVISION != REV_FIRST);

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	logic edge_below;
	logic level_below;
	logic pin_low_n;
	logic reg_low;

	// Pin idles high behind its pull-up; the monitors idle low
	sync2 #(.RESET_VAL(1'b0)) u_sync_edge (.CLK(CLK), .RESETN(RESETN),
		.D(EDGE_MON_BELOW), .Q(edge_below));
	sync2 #(.RESET_VAL(1'b0)) u_sync_level (.CLK(CLK), .RESETN(RESETN),
		.D(LEVEL_MON_BELOW), .Q(level_below));
	sync2 #(.RESET_VAL(1'b1)) u_sync_pin (.CLK(CLK), .RESETN(RESETN),
		.D(RST_PIN_IN), .Q(pin_low_n));
	sync2 #(.RESET_VAL(1'b0)) u_sync_reg (.CLK(CLK), .RESETN(RESETN),
		.D(REG_BELOW_HIGH), .Q(reg_low));

	// Level monitor only exists on the third revision
	logic level_src;
	assign level_src = HAS_LEVEL & level_below;

	// Our own drive echoes through the pin synchroniser for two cycles after
	// release, so its recent history masks the pin too; an outside pull in
	// that short gap is seen two cycles late
	logic [1:0] oe_hist;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			oe_hist <= 2'b00;
		end else begin
			oe_hist <= {oe_hist[0], RST_PIN_OE};
		end
	end

	// Pin is low only when outside circuitry pulls it; our own drive is excluded
	logic pin_src;
	assign pin_src = ~pin_low_n & ~RST_PIN_OE & ~(|oe_hist);

	logic any_src;
	assign any_src = edge_below | level_src | pin_src;

	// ----------------------------------------
	// Threshold selection and lock-up
	// ----------------------------------------
	// Power-on reset forces the low threshold
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			THRESH_SEL <= THRESH_LOW;
		end else if (CORE_RESETN) begin
			THRESH_SEL <= HIGH_THRESH_REQ ? THRESH_HIGH : THRESH_LOW;
		end
	end

	// Early revisions lose calibration on any reset: with the high threshold
	// the raw regulator output trips the monitor and only power-on frees it.
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			LOCKED <= 1'b0;
		end else if (EARLY_REV && THRESH_SEL == THRESH_HIGH && reg_low
				&& any_src && CORE_RESETN) begin
			LOCKED <= 1'b1;
		end
	end

	// ----------------------------------------
	// External pin drive
	// ----------------------------------------
	// Only monitor brownouts drive the pin; first revision never drives it
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RST_PIN_OE <= 1'b0;
		end else begin
			RST_PIN_OE <= DRIVE_PIN & (edge_below | level_src);
		end
	end
	assign RST_PIN_OUT = 1'b0;

	// ----------------------------------------
	// Startup sequence
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_CAL  = 2'b01,
		ST_WAIT = 2'b10,
		ST_RUN  = 2'b11
	} seq_state_t;

	seq_state_t        state;
	logic [HOLD_W-1:0] cnt;
	logic              first_done;
	logic              calibrated;

	// Delay for this release: long only for the first power-up on revision one
	logic [HOLD_W-1:0] hold_cnt;
	assign hold_cnt = (REVISION == REV_FIRST && !first_done) ? LONG_CNT : SHORT_CNT;

	// Calibration needed after every reset early, only after power-on later
	logic need_cal;
	assign need_cal = EARLY_REV ? 1'b1 : ~calibrated;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state <= ST_HOLD;
			cnt   <= '0;
		end else if (any_src || LOCKED) begin
			state <= ST_HOLD;
			cnt   <= '0;
		end else begin
			unique case (state)
				ST_HOLD: begin
					state <= need_cal ? ST_CAL : ST_WAIT;
					cnt   <= need_cal ? CAL_CNT : hold_cnt;
				end
				ST_CAL: begin
					if (cnt <= HOLD_W'(1)) begin
						state <= ST_WAIT;
						cnt   <= hold_cnt;
					end else begin
						cnt <= cnt - HOLD_W'(1);
					end
				end
				ST_WAIT: begin
					if (cnt <= HOLD_W'(1)) begin
						state <= ST_RUN;
					end else begin
						cnt <= cnt - HOLD_W'(1);
					end
				end
				ST_RUN: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	// Remember the first power-up and regulator calibration
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			first_done <= 1'b0;
			calibrated <= 1'b0;
		end else begin
			if (state == ST_RUN) begin
				first_done <= 1'b1;
			end
			// Only a finished calibration counts; one cut short is repeated
			if (state == ST_CAL && cnt <= HOLD_W'(1) && !any_src && !LOCKED) begin
				calibrated <= 1'b1;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			CORE_RESETN <= 1'b0;
			CAL_START   <= 1'b0;
		end else begin
			CORE_RESETN <= (state == ST_RUN) && !any_src && !LOCKED;
			CAL_START   <= (state == ST_HOLD) && need_cal && !any_src && !LOCKED;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_pin_first_rev: assert property (@(posedge CLK) disable iff (!RESETN)
		(REVISION == REV_FIRST) |-> !RST_PIN_OE)
		else $error("Pin driven on first revision");

	a_pin_brownout: assert property (@(posedge CLK) disable iff (!RESETN)
		(DRIVE_PIN && edge_below) |=> RST_PIN_OE)
		else $error("Pin not driven during brownout");

	a_core_sources: assert property (@(posedge CLK) disable iff (!RESETN)
		(any_src || LOCKED) |=> !CORE_RESETN)
		else $error("Core released with source active");

	a_release_order: assert property (@(posedge CLK) disable iff (!RESETN)
		$rose(CORE_RESETN) |-> $past(state) == ST_RUN)
		else $error("Core released before delay");

	a_level_hold: assert property (@(posedge CLK) disable iff (!RESETN)
		(HAS_LEVEL && level_below) |=> !CORE_RESETN)
		else $error("Level monitor did not hold reset");

	a_lock_hold: assert property (@(posedge CLK) disable iff (!RESETN)
		LOCKED |=> LOCKED && !CORE_RESETN)
		else $error("Lock released without power-on");

	a_lock_late_rev: assert property (@(posedge CLK) disable iff (!RESETN)
		(REVISION == REV_THIRD) |-> !LOCKED)
		else $error("Lock on third revision");

	a_cal_every: assert property (@(posedge CLK) disable iff (!RESETN)
		(EARLY_REV && state == ST_HOLD && !any_src && !LOCKED) |=> state == ST_CAL)
		else $error("Early revision skipped calibration");

	a_cal_once: assert property (@(posedge CLK) disable iff (!RESETN)
		(!EARLY_REV && calibrated && state == ST_HOLD && !any_src) |=> state != ST_CAL)
		else $error("Third revision recalibrated");

	a_wait_load: assert property (@(posedge CLK) disable iff (!RESETN)
		(REVISION != REV_FIRST && state == ST_CAL && cnt == HOLD_W'(1) && !any_src)
		|=> cnt == SHORT_CNT)
		else $error("Wrong startup delay");

	a_thresh_reset: assert property (@(posedge CLK) disable iff (!RESETN)
		!CORE_RESETN && !$past(CORE_RESETN) && !first_done |-> THRESH_SEL == THRESH_LOW)
		else $error("Threshold not low after power-on");

endmodule // revision_aware_reset_sequencer
`default_nettype wire

// ### tb/rst_partner.sv
// Far-side model: external reset circuit with pull-up, and flash firmware.
// Assumes one copy per sequencer; the bench commands pulses and flash writes.
`timescale 1ns/1ps
`default_nettype none
module rst_partner (
	input  wire logic PIN_OE,
	input  wire logic PIN_OUT,
	input  wire logic EXT_LOW,
	input  wire logic FLASH_ON,
	output logic      PIN_LEVEL,
	output logic      THRESH_REQ
);
	// ----------------------------------------
	// Wire and firmware
	// ----------------------------------------
	// Pull-up wins unless a party pulls low; pulse length is the bench's job
	assign PIN_LEVEL  = !(EXT_LOW || (PIN_OE && !PIN_OUT));
	// High threshold only around a flash write, low otherwise
	assign THRESH_REQ = FLASH_ON;
endmodule // rst_partner
`default_nettype wire

// ### tb/revision_aware_reset_sequencer_bench.sv
// Bench: one sequencer per revision, each with its own far-side model.
// Assumes short hold counts so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module revision_aware_reset_sequencer_bench
	import rst_seq_pkg::*;
;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	localparam int LH = 60;
	localparam int SH = 10;
	logic       clk, resetn, edge_low, level_low, reg_low, flash_on, ext_low;
	logic [2:0] oe, pout, core, tsel, cal, lock, pin, treq;
	int         err_total, cmp_count, t [3], ncal [3];
	logic [7:0] lfsr;
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	for (genvar i = 0; i < 3; i++) begin : g_rev
		revision_aware_reset_sequencer #(.REVISION(revision_t'(i)), .LONG_HOLD(LH),
			.SHORT_HOLD(SH)) u_revision_aware_reset_sequencer (.CLK(clk), .RESETN(resetn),
			.EDGE_MON_BELOW(edge_low), .LEVEL_MON_BELOW(level_low), .RST_PIN_IN(pin[i]),
			.HIGH_THRESH_REQ(treq[i]), .REG_BELOW_HIGH(reg_low), .RST_PIN_OUT(pout[i]),
			.RST_PIN_OE(oe[i]), .CORE_RESETN(core[i]), .THRESH_SEL(tsel[i]),
			.CAL_START(cal[i]), .LOCKED(lock[i]));
		rst_partner u_rst_partner (.PIN_OE(oe[i]), .PIN_OUT(pout[i]), .EXT_LOW(ext_low),
			.FLASH_ON(flash_on), .PIN_LEVEL(pin[i]), .THRESH_REQ(treq[i]));
	end
	// Calibration pulses counted all the time, as they may come mid-reset
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++) if (cal[i] === 1'b1) ncal[i] <= ncal[i] + 1;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] next_rand(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic por();
		ncal = '{default: 0};
		resetn = 1'b0;
		tick(5);
		chk("outputs in reset", {oe, core, tsel, cal, lock}, 32'h0);
		resetn = 1'b1;
	endtask
	// Records cycles to each release; a hang ends the run
	task automatic wait_release(input int bound);
		int n;
		n = 0;
		t = '{default: -1};
		while (core !== 3'b111 && n < bound) begin
			tick(1);
			n++;
			for (int i = 0; i < 3; i++) if (core[i] === 1'b1 && t[i] < 0) t[i] = n;
		end
		if (n >= bound) begin
			err_total++;
			$display("ERROR release expected before %0d seen timeout", bound);
			stop_test();
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{resetn, edge_low, level_low, reg_low, flash_on, ext_low} = 6'h0;
		{err_total, cmp_count, lfsr} = {32'd0, 32'd0, 8'h3b};
		por();
		wait_release(300);
		for (int i = 0; i < 3; i++) begin
			chk("power-on calibration", ncal[i], 32'd1);
			chk("startup hold", t[i] > (i == 0 ? LH : SH) && t[i] < (i == 0 ? LH : SH) + 40,
				1'b1);
		end
		// Random brownout widths; the pin may be driven only on later revisions
		repeat (3) begin
			lfsr = next_rand(lfsr);
			ncal = '{default: 0};
			reg_low = lfsr[4];
			edge_low = 1'b1;
			tick(6 + lfsr[3:0]);
			chk("core in brownout", core, 3'b000);
			chk("pin drive in brownout", {oe, pout}, 6'b110000);
			edge_low = 1'b0;
			tick(6);
			chk("pin released", oe, 3'b000);
			chk("no lock at low threshold", lock, 3'b000);
			wait_release(300);
			chk("no long hold again", t[0] < LH, 1'b1);
			for (int i = 0; i < 3; i++) chk("recalibration", ncal[i], i < 2);
		end
		// Slow ramp held off by the level monitor of the newest part only
		level_low = 1'b1;
		por();
		tick(150);
		chk("level monitor hold", core, 3'b011);
		level_low = 1'b0;
		wait_release(300);
		// Pin reset at high threshold with uncalibrated regulator
		flash_on = 1'b1;
		tick(4);
		chk("high threshold", tsel, 3'b111);
		reg_low = 1'b1;
		lfsr = next_rand(lfsr);
		ext_low = 1'b1;
		tick(2 + lfsr[2:0]);
		ext_low = 1'b0;
		tick(100);
		chk("lock and core", {lock, core}, 6'b011100);
		{flash_on, reg_low} = 2'b00;
		tick(20);
		chk("lock kept", lock, 3'b011);
		por();
		wait_release(300);
		chk("threshold and lock after power-on", {tsel, lock}, 6'b0);
		stop_test();
	end
endmodule // revision_aware_reset_sequencer_bench
`default_nettype wire
